// >>> od_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// command link between host controller and protection device
// ----------------------------------------------------------------
interface od_link_if;
	logic       req;    // host holds until ack or nak
	logic [1:0] cmd;    // command code
	logic [7:0] wdata;  // write byte
	logic       ack;    // one-cycle pulse, command done
	logic       nak;    // one-cycle pulse, refused while asleep
	logic [7:0] rdata;  // read byte, valid with ack

	modport device (input req, input cmd, input wdata,
		output ack, output nak, output rdata);
	modport host (output req, output cmd, output wdata,
		input ack, input nak, input rdata);
endinterface : od_link_if

// >>> od_sleep_device.sv
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// ----------------------------------------------------------------
// over-discharge and sleep controller, device end
// ----------------------------------------------------------------

module od_sleep_device #(
	parameter logic [od_sleep_pkg::CNT_W-1:0] DETECT_CYCLES =
		od_sleep_pkg::DETECT_CYCLES_DEF,
	parameter logic [od_sleep_pkg::CNT_W-1:0] RELEASE_CYCLES =
		od_sleep_pkg::RELEASE_CYCLES_DEF,
	parameter logic [od_sleep_pkg::CNT_W-1:0] WAKE_CYCLES =
		od_sleep_pkg::WAKE_CYCLES_DEF
) (
	input  wire logic                           ref_clk,
	input  wire logic                           rst,
	od_link_if.device                           link,
	input  wire logic [od_sleep_pkg::CELLS-1:0] cell_under_uv,
	input  wire logic [od_sleep_pkg::CELLS-1:0] cell_above_release,
	input  wire logic [od_sleep_pkg::CELLS-1:0] cell_above_charge_en,
	input  wire logic                           vcc_above_return,
	output logic                                discharge_switch_drive,
	output logic                                charge_switch_drive,
	output logic                                regulated_output,
	output logic [1:0]                          undervolt_sel,
	output logic [1:0]                          charge_enable_sel,
	output logic                                asleep
);
	import od_sleep_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RUN,      // awake, switches follow control
		ST_DETECT,   // detection delay running
		ST_SLEEP,    // powered down
		ST_WAKE,     // internal reset after wake
		ST_BLOCKED   // charge check failed
	} mode_e;

	typedef struct packed {
		mode_e            mode;     // controller mode
		logic [CNT_W-1:0] cnt;      // shared delay counter
		logic             od;       // over-discharge protection held
		logic [SYN_W-1:0] s1;       // synchroniser stage 1
		logic [SYN_W-1:0] s2;       // synchroniser stage 2
		logic [SYN_W-1:0] s3;       // synchroniser stage 3
		logic [SYN_W-1:0] filt;     // accepted comparator levels
		logic [2:0]       ctl;      // control byte
		logic [CFG_W-1:0] cfg;      // configuration byte
		logic             ack;      // link done pulse
		logic             nak;      // link refused pulse
		logic [7:0]       rdata;    // link read byte
		logic             dis_off;  // discharge drive, high is off
		logic             chg_off;  // charge drive, high is off
		logic             reg_on;   // regulator enable
	} dev_s;

	// switches off and regulator on from reset onward
	localparam dev_s DEV_RST = '{mode: ST_RUN, ctl: CTL_RST,
		cfg: CFG_RST, dis_off: 1'b1, chg_off: 1'b1, reg_on: 1'b1,
		default: '0};

	dev_s             st;        // registered state
	dev_s             next_st;   // next state
	logic             take;      // link command accepted this cycle
	logic             any_uv;    // some cell below threshold
	logic             all_uvr;   // all cells above release level
	logic             all_ce;    // all cells above charge-enable level
	logic             vcc_hi;    // supply at or above return level
	logic             check_ok;  // charge check passes or is off
	logic             awake_ctl; // control bits may steer switches
	logic             dis_wr;    // discharge ctl written with 1 now
	logic [CNT_W-1:0] cnt_inc;   // counter plus one

	// ----------------------------------------------------------------
	// outputs from flops, asleep decoded from the mode flops
	// ----------------------------------------------------------------
	assign discharge_switch_drive = st.dis_off;
	assign charge_switch_drive    = st.chg_off;
	assign regulated_output       = st.reg_on;
	assign asleep                 = st.mode == ST_SLEEP;
	assign undervolt_sel          = st.cfg[CFG_UV_LO +: 2];
	assign charge_enable_sel      = st.cfg[CFG_CE_LO +: 2];
	assign link.ack               = st.ack;
	assign link.nak               = st.nak;
	assign link.rdata             = st.rdata;

	// ----------------------------------------------------------------
	// accepted comparator levels
	// ----------------------------------------------------------------
	// only the filtered copy is used, never a raw stage
	assign any_uv   = |st.filt[SYN_UV +: CELLS];
	assign all_uvr  = &st.filt[SYN_UVR +: CELLS];
	assign all_ce   = &st.filt[SYN_CE +: CELLS];
	assign vcc_hi   = st.filt[SYN_VCC];
	// a set disable bit acts as a zero-volt charge-enable level
	assign check_ok = st.cfg[CFG_CHK_DIS] || all_ce;
	assign cnt_inc  = st.cnt + CNT_ONE;
	// a new command is taken only between answer pulses
	assign take     = link.req && !st.ack && !st.nak;
	// switch control bits are ignored asleep, in wake reset and when blocked
	assign awake_ctl = st.mode == ST_RUN || st.mode == ST_DETECT;
	// a software write landing on the release edge must not be lost
	assign dis_wr    = take && awake_ctl && link.cmd == CMD_CTRL_WR &&
		link.wdata[CTL_DIS];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st     = st;
		next_st.ack = 1'b0;
		next_st.nak = 1'b0;

		// three flops, a level counts once stages two and three agree
		next_st.s1   = {vcc_above_return, cell_above_charge_en,
			cell_above_release, cell_under_uv};
		next_st.s2   = st.s1;
		next_st.s3   = st.s2;
		next_st.filt = (st.s2 & st.s3) |
			(st.filt & (st.s2 | st.s3));

		// link commands
		if (take) begin
			if (st.mode == ST_SLEEP) begin
				next_st.nak = 1'b1;
			end else begin
				next_st.ack = 1'b1;
				case (link.cmd)
					CMD_CTRL_WR: begin
						// switch bits only while awake, in run or detection
						if (awake_ctl) begin
							next_st.ctl[CTL_DIS] = link.wdata[CTL_DIS];
							next_st.ctl[CTL_CHG] = link.wdata[CTL_CHG];
						end
						next_st.ctl[CTL_SLEEP] = link.wdata[CTL_SLEEP];
					end
					CMD_CFG_WR: begin
						next_st.cfg = link.wdata[CFG_W-1:0];
					end
					CMD_CTRL_RD: begin
						next_st.rdata = {st.od, st.mode == ST_BLOCKED,
							st.mode == ST_WAKE, 2'b00, st.ctl};
					end
					CMD_CFG_RD: begin
						next_st.rdata = {3'b000, st.cfg};
					end
					default: begin
						next_st.rdata = 8'h00;
					end
				endcase
			end
		end

		// mode sequencing
		case (st.mode)
			ST_RUN: begin
				if (st.od) begin
					// release counts only with the charge switch on
					if (st.ctl[CTL_CHG] && all_uvr) begin
						next_st.cnt = cnt_inc;
						if (cnt_inc == RELEASE_CYCLES) begin
							next_st.od = 1'b0;
							// a fresh write of 1 is needed after release
							next_st.ctl[CTL_DIS] = dis_wr;
						end
					end else begin
						next_st.cnt = '0;
					end
				end else if (any_uv) begin
					// first drop: start the delay, stay in operation
					next_st.mode = ST_DETECT;
					next_st.cnt  = '0;
				end
				// pending sleep waits while the supply is high
				if (st.ctl[CTL_SLEEP] && !vcc_hi) begin
					next_st.mode = ST_SLEEP;
				end
			end
			ST_DETECT: begin
				next_st.cnt = cnt_inc;
				if (!any_uv) begin
					next_st.mode = ST_RUN;
				end else if (cnt_inc == DETECT_CYCLES) begin
					next_st.od  = 1'b1;
					next_st.cnt = '0;
					// both switches off and both bits cleared
					next_st.ctl[CTL_DIS] = 1'b0;
					next_st.ctl[CTL_CHG] = 1'b0;
					// protected but awake while supply is high
					next_st.mode = vcc_hi ? ST_RUN : ST_SLEEP;
				end
				if (st.ctl[CTL_SLEEP] && !vcc_hi) begin
					next_st.mode = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				next_st.ctl = CTL_RST;
				next_st.cnt = '0;
				if (vcc_hi) begin
					next_st.mode = ST_WAKE;
				end
			end
			ST_WAKE: begin
				next_st.cnt = cnt_inc;
				if (cnt_inc == WAKE_CYCLES) begin
					next_st.cnt  = '0;
					next_st.mode = check_ok ? ST_RUN : ST_BLOCKED;
				end
			end
			ST_BLOCKED: begin
				if (check_ok) begin
					next_st.mode = ST_RUN;
				end
			end
			default: begin
				next_st.mode = ST_SLEEP;
			end
		endcase

		// drives follow the next mode so entry acts at once
		if (next_st.mode == ST_RUN || next_st.mode == ST_DETECT) begin
			next_st.dis_off = next_st.od ||
				!next_st.ctl[CTL_DIS];
			next_st.chg_off = !next_st.ctl[CTL_CHG];
		end else begin
			next_st.dis_off = 1'b1;
			next_st.chg_off = 1'b1;
		end
		next_st.reg_on = next_st.mode != ST_SLEEP;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= DEV_RST;
		end else begin
			st <= next_st;
		end
	end

endmodule : od_sleep_device

// >>> od_sleep_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host end: ahb-lite slave that issues link commands
// ----------------------------------------------------------------
module od_sleep_host (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	od_link_if.host          link,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	import od_sleep_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        ph_valid;  // data phase pending
		logic        ph_write;  // pending phase is a write
		logic [31:0] ph_addr;   // pending phase address
		logic        rd_done;   // read data loaded
		logic [31:0] rdata;     // bus read data
		logic        req;       // link request
		logic [1:0]  cmd;       // link command
		logic [7:0]  wdata;     // link write byte
		logic        nak_seen;  // last command refused
		logic [7:0]  last_rd;   // last byte read back
	} host_s;

	host_s st;       // registered state
	host_s next_st;  // next state

	// ----------------------------------------------------------------
	// handshake outputs
	// ----------------------------------------------------------------
	// reads take one wait state so hrdata comes from a flop
	assign hreadyout  = !(st.ph_valid && !st.ph_write && !st.rd_done);
	assign hresp      = 1'b0;
	assign hrdata     = st.rdata;
	assign link.req   = st.req;
	assign link.cmd   = st.cmd;
	assign link.wdata = st.wdata;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// data phase of a write: start a command unless one runs
		if (st.ph_valid && st.ph_write && st.ph_addr == REG_CMD &&
		    !st.req) begin
			next_st.req   = 1'b1;
			next_st.cmd   = hwdata[CMDR_CODE +: 2];
			next_st.wdata = hwdata[7:0];
		end
		// data phase of a read: load once, then release hready
		if (st.ph_valid && !st.ph_write && !st.rd_done) begin
			next_st.rd_done = 1'b1;
			next_st.rdata   = '0;
			if (st.ph_addr == REG_STAT) begin
				next_st.rdata[STAT_BUSY]     = st.req;
				next_st.rdata[STAT_NAK]      = st.nak_seen;
				next_st.rdata[STAT_DATA +: 8] = st.last_rd;
			end
		end
		// end of a command seen from the device
		if (st.req && (link.ack || link.nak)) begin
			next_st.req      = 1'b0;
			next_st.nak_seen = link.nak;
			if (link.ack) begin
				next_st.last_rd = link.rdata;
			end
		end
		// address phase taken whenever the bus is ready
		if (hready) begin
			next_st.ph_valid = hsel && htrans[1];
			next_st.ph_write = hwrite;
			next_st.ph_addr  = haddr;
			next_st.rd_done  = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : od_sleep_host

// >>> od_sleep_pkg.sv
package od_sleep_pkg;

	// ----------------------------------------------------------------
	// cells, clock and delay timing
	// ----------------------------------------------------------------
	localparam int CELLS            = 4;       // cells watched
	localparam int CNT_W            = 24;      // delay counter width
	localparam int CLK_HZ           = 10_000_000;
	localparam int CYC_PER_MS       = CLK_HZ / 1000;
	localparam int DETECT_DELAY_MS  = 1000;    // detection delay, 1.0 s
	localparam int RELEASE_DELAY_MS = 7;       // release delay, 7 ms
	localparam int WAKE_EXTRA_MS    = 200;     // added to wake reset
	localparam int WAKE_RESET_MS    = DETECT_DELAY_MS + WAKE_EXTRA_MS;
	localparam logic [CNT_W-1:0] DETECT_CYCLES_DEF  =
		CNT_W'(DETECT_DELAY_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] RELEASE_CYCLES_DEF =
		CNT_W'(RELEASE_DELAY_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] WAKE_CYCLES_DEF    =
		CNT_W'(WAKE_RESET_MS * CYC_PER_MS);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	// ----------------------------------------------------------------
	// synchronised comparator vector layout
	// ----------------------------------------------------------------
	localparam int SYN_W    = 3 * CELLS + 1;
	localparam int SYN_UV   = 0;               // cell below threshold
	localparam int SYN_UVR  = CELLS;           // cell above release
	localparam int SYN_CE   = 2 * CELLS;       // cell above charge enable
	localparam int SYN_VCC  = 3 * CELLS;       // supply at return level

	// ----------------------------------------------------------------
	// link commands
	// ----------------------------------------------------------------
	localparam logic [1:0] CMD_CTRL_WR = 2'h0; // control write
	localparam logic [1:0] CMD_CFG_WR  = 2'h1; // configuration write
	localparam logic [1:0] CMD_CTRL_RD = 2'h2; // control and status read
	localparam logic [1:0] CMD_CFG_RD  = 2'h3; // configuration read

	// ----------------------------------------------------------------
	// control byte fields
	// ----------------------------------------------------------------
	localparam int CTL_DIS     = 0;            // discharge_switch_ctl
	localparam int CTL_CHG     = 1;            // charge_switch_ctl
	localparam int CTL_SLEEP   = 2;            // sleep_request
	localparam int STS_WAKING  = 5;            // wake reset running
	localparam int STS_BLOCKED = 6;            // charge check failed
	localparam int STS_OD      = 7;            // over-discharge held
	localparam logic [2:0] CTL_RST = 3'h0;

	// ----------------------------------------------------------------
	// configuration byte fields
	// ----------------------------------------------------------------
	localparam int CFG_UV_LO   = 0;            // undervolt_sel lo/hi
	localparam int CFG_CE_LO   = 2;            // charge_enable_sel lo/hi
	localparam int CFG_CHK_DIS = 4;            // charge_check_disable
	localparam int CFG_W       = 5;
	localparam logic [CFG_W-1:0] CFG_RST = 5'h00;

	// ----------------------------------------------------------------
	// host registers on the bus
	// ----------------------------------------------------------------
	localparam logic [31:0] REG_CMD  = 32'h0000_0000;
	localparam logic [31:0] REG_STAT = 32'h0000_0004;
	localparam int CMDR_CODE = 8;              // code field of REG_CMD
	localparam int STAT_BUSY = 0;
	localparam int STAT_NAK  = 1;
	localparam int STAT_DATA = 8;

endpackage : od_sleep_pkg

// >>> od_sleep_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link and switch-drive checker
// ----------------------------------------------------------------
module od_sleep_sva #(
	parameter int DETECT_CYCLES = 20
) (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       req,
	input wire logic       ack,
	input wire logic       nak,
	input wire logic [7:0] rdata,
	input wire logic       asleep,
	input wire logic       discharge_switch_drive,
	input wire logic       charge_switch_drive,
	input wire logic       regulated_output,
	input wire logic       vcc_above_return,
	input wire logic [3:0] cell_under_uv
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic [9:0] under_cnt; // consecutive cycles with any cell low

	// saturating count, so a long dip cannot wrap back into the window
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			under_cnt <= '0;
		else if (!(|cell_under_uv))
			under_cnt <= '0;
		else if (under_cnt != 10'h3ff)
			under_cnt <= under_cnt + 10'h001;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_nak_asleep;
		req && !ack && !nak && asleep |=> nak && !ack;
	endproperty
	a_nak_asleep: assert property (p_nak_asleep)
		else $error("command taken in sleep was not refused");
	property p_ack_awake;
		req && !ack && !nak && !asleep |=> ack && !nak;
	endproperty
	a_ack_awake: assert property (p_ack_awake)
		else $error("command taken while awake was not acknowledged");
	property p_one_answer;
		(ack || nak) |=> !(ack || nak);
	endproperty
	a_one_answer: assert property (p_one_answer)
		else $error("answer pulse lasted more than one cycle");
	property p_rdata_ack;
		$changed(rdata) |-> ack;
	endproperty
	a_rdata_ack: assert property (p_rdata_ack)
		else $error("read byte changed without an acknowledge");
	property p_sleep_off;
		asleep |-> discharge_switch_drive && charge_switch_drive
			&& !regulated_output;
	endproperty
	a_sleep_off: assert property (p_sleep_off)
		else $error("switch or regulator on during sleep");
	property p_no_sleep_vcc;
		vcc_above_return [*6] |-> !$rose(asleep);
	endproperty
	a_no_sleep_vcc: assert property (p_no_sleep_vcc)
		else $error("sleep entered with supply at return level");
	property p_wake;
		$rose(vcc_above_return) && asleep
			|-> ##[1:10] (!asleep && regulated_output);
	endproperty
	a_wake: assert property (p_wake)
		else $error("no wake within ten cycles of supply return");
	property p_detect_hold;
		under_cnt != 10'h000 && under_cnt < 10'(DETECT_CYCLES)
			&& !$past(discharge_switch_drive) |-> !discharge_switch_drive;
	endproperty
	a_detect_hold: assert property (p_detect_hold)
		else $error("discharge switch off before detection delay");
	property p_od_drives;
		under_cnt == 10'(DETECT_CYCLES + 8)
			|-> discharge_switch_drive && charge_switch_drive;
	endproperty
	a_od_drives: assert property (p_od_drives)
		else $error("switches still on after detection delay");

	// ----------------------------------------------------------------
	// main scenarios reached
	// ----------------------------------------------------------------
	c_nak: cover property (nak);
	c_sleep: cover property ($rose(asleep));
	c_wake: cover property ($fell(asleep));
	c_dis_on: cover property ($fell(discharge_switch_drive));
endmodule : od_sleep_sva

// >>> test_overdischarge_sleep_controller.sv
`timescale 1ns/1ps
module test_overdischarge_sleep_controller;
	import od_sleep_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int DETECT_N = 20; // shortened delays for simulation
	logic             ref_clk;
	logic             rst;
	logic             hsel;
	logic [31:0]      haddr;
	logic [1:0]       htrans;
	logic             hwrite;
	logic [2:0]       hsize;
	logic [31:0]      hwdata;
	logic             hready;     // the one slave's hreadyout
	logic             hresp;
	logic [31:0]      hrdata;
	logic [CELLS-1:0] cell_under_uv;
	logic [CELLS-1:0] cell_above_release;
	logic [CELLS-1:0] cell_above_charge_en;
	logic             vcc_above_return;
	logic             discharge_switch_drive;
	logic             charge_switch_drive;
	logic             regulated_output;
	logic [1:0]       undervolt_sel;
	logic [1:0]       charge_enable_sel;
	logic             asleep;
	int               failures;
	int               check_count;
	int               cycles;
	logic [31:0]      rword;      // last bus read
	logic [7:0]       rbyte;      // byte returned by a link read
	logic             nakd;       // last link command refused

	od_link_if link ();

	od_sleep_host i_od_sleep_host (.ref_clk(ref_clk), .rst(rst),
		.link(link.host), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
	od_sleep_device #(.DETECT_CYCLES(CNT_W'(DETECT_N)),
		.RELEASE_CYCLES(CNT_W'(8)), .WAKE_CYCLES(CNT_W'(30)))
		i_od_sleep_device (.ref_clk(ref_clk), .rst(rst),
		.link(link.device), .cell_under_uv(cell_under_uv),
		.cell_above_release(cell_above_release),
		.cell_above_charge_en(cell_above_charge_en),
		.vcc_above_return(vcc_above_return),
		.discharge_switch_drive(discharge_switch_drive),
		.charge_switch_drive(charge_switch_drive),
		.regulated_output(regulated_output),
		.undervolt_sel(undervolt_sel),
		.charge_enable_sel(charge_enable_sel), .asleep(asleep));
	od_sleep_sva #(.DETECT_CYCLES(DETECT_N)) i_od_sleep_sva (
		.ref_clk(ref_clk), .rst(rst), .req(link.req), .ack(link.ack),
		.nak(link.nak), .rdata(link.rdata), .asleep(asleep),
		.discharge_switch_drive(discharge_switch_drive),
		.charge_switch_drive(charge_switch_drive),
		.regulated_output(regulated_output),
		.vcc_above_return(vcc_above_return), .cell_under_uv(cell_under_uv));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// pins in order: discharge drive, charge drive, regulator, asleep
	task automatic pins(input logic [3:0] exp);
		chk({28'h0, discharge_switch_drive, charge_switch_drive,
			regulated_output, asleep}, {28'h0, exp});
	endtask : pins

	// one single transfer; entered just after a rising edge
	task automatic ahb(input logic wr, input logic [31:0] addr,
		input logic [31:0] wd);
		haddr  <= addr;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge ref_clk);
		while (hready !== 1'b1) @(posedge ref_clk);
		rword = hrdata;
	endtask : ahb

	// issue a link command, then poll status until it is done
	task automatic link_cmd(input logic [1:0] c, input logic [7:0] d);
		int n = 0;
		ahb(1'b1, REG_CMD, {22'h0, c, d});
		do begin
			ahb(1'b0, REG_STAT, 32'h0);
			n++;
		end while (rword[STAT_BUSY] !== 1'b0 && n < 50);
		chk({31'h0, rword[STAT_BUSY]}, 32'h0);
		rbyte = rword[STAT_DATA +: 8];
		nakd  = rword[STAT_NAK];
	endtask : link_cmd

	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// whole run needs well under two thousand cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{failures, check_count, cycles} = '0;
		{rst, hsel, hsize} = {1'b1, 1'b1, 3'h2};
		{haddr, htrans, hwrite, hwdata} = '0;
		{cell_under_uv, cell_above_release} = '0;
		cell_above_charge_en = '1;
		vcc_above_return = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		// both selects, every value, and an unmapped read
		pins(4'b1110);
		for (int i = 0; i < 4; i++) begin
			link_cmd(CMD_CFG_WR, 8'(4 * i + 3 - i));
			chk({30'h0, undervolt_sel}, 32'(3 - i));
			chk({30'h0, charge_enable_sel}, 32'(i));
			link_cmd(CMD_CFG_RD, 8'h00);
			chk({24'h0, rbyte}, 32'(4 * i + 3 - i));
		end
		ahb(1'b0, 32'h0000_0010, 32'h0);
		chk(rword, 32'h0);
		$display("test 1 done");
		// software turns both switches on
		link_cmd(CMD_CTRL_WR, 8'h03);
		pins(4'b0010);
		$display("test 2 done");
		// a dip shorter than the delay leaves the switches on
		cell_under_uv <= 4'b0001;
		repeat (10) @(posedge ref_clk);
		cell_under_uv <= 4'b0000;
		repeat (30) @(posedge ref_clk);
		pins(4'b0010);
		// one cell low past the detection delay
		cell_under_uv <= 4'b0100;
		repeat (18) @(posedge ref_clk);
		pins(4'b0010);
		repeat (14) @(posedge ref_clk);
		pins(4'b1101);
		cell_under_uv <= 4'b0000;
		$display("test 3 done");
		// a control write and a configuration read refused while asleep
		link_cmd(CMD_CTRL_WR, 8'h03);
		chk({31'h0, nakd}, 32'h1);
		link_cmd(CMD_CFG_RD, 8'h00);
		chk({31'h0, nakd}, 32'h1);
		pins(4'b1101);
		$display("test 4 done");
		// wake with one cell under the charge-enable level
		cell_above_charge_en <= 4'b1011;
		vcc_above_return <= 1'b1;
		repeat (12) @(posedge ref_clk);
		pins(4'b1110);
		link_cmd(CMD_CTRL_RD, 8'h00);
		chk({23'h0, nakd, rbyte}, 32'h0000_00a0);
		repeat (40) @(posedge ref_clk);
		link_cmd(CMD_CTRL_RD, 8'h00);
		chk({24'h0, rbyte}, 32'h0000_00c0);
		link_cmd(CMD_CTRL_WR, 8'h03);
		pins(4'b1110);
		$display("test 5 done");
		// check disabled: charge switch may turn on
		link_cmd(CMD_CFG_WR, 8'h10);
		link_cmd(CMD_CTRL_RD, 8'h00);
		chk({24'h0, rbyte}, 32'h0000_0080);
		link_cmd(CMD_CTRL_WR, 8'h03);
		pins(4'b1010);
		$display("test 6 done");
		// release: discharge needs a fresh write
		cell_above_release <= 4'hf;
		repeat (16) @(posedge ref_clk);
		link_cmd(CMD_CTRL_RD, 8'h00);
		chk({24'h0, rbyte}, 32'h0000_0002);
		pins(4'b1010);
		link_cmd(CMD_CTRL_WR, 8'h03);
		pins(4'b0010);
		$display("test 7 done");
		// sleep request held off by a high supply
		link_cmd(CMD_CTRL_WR, 8'h07);
		repeat (12) @(posedge ref_clk);
		pins(4'b0010);
		vcc_above_return <= 1'b0;
		repeat (12) @(posedge ref_clk);
		pins(4'b1101);
		$display("test 8 done");
		print_verdict();
	end
endmodule : test_overdischarge_sleep_controller
